// file: design/program_sequencer.sv
// Program sequencer: phase timing, fetch pipeline, counter, stack and vectors
// Summary of operation
// - four system clocks per instruction cycle
// - fetch one cycle, execute the next
// - counter-changing instructions take two cycles
// - counter is thirteen bits wide
// - counter increments after each fetch
// - met skip flushes next, counter plus two
// - load counter from code or stack
// - reset clears counter to zero
// - external interrupts vector to 004, 008
// - first timer overflow vectors to 00C
// - second timer overflow vectors to 010
// - serial transfer done vectors to 014
// - multi-function events vector to 018
// - low byte write gives short jump
// - table address from page or last page
// - table low byte out, high byte latched
// - table reads take two cycles
// - hold 1024 clocks after power-up or wake
// - push on call or interrupt, pop on return
// - full stack holds off interrupt acknowledge
// - sixteen levels, overflow loses oldest
`timescale 1ns/10ps

module program_sequencer
  import program_sequencer_pkg::*;
#(
  parameter int STARTUP_LEN = STARTUP_CYCLES,
  parameter int DEPTH       = STACK_DEPTH
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // Wake from halt request
  input  wire logic                       wake_i,
  // Program memory
  output logic [program_sequencer_pkg::PC_W-1:0]   prog_addr_o,
  output logic                            prog_rd_o,
  input  wire logic [program_sequencer_pkg::WORD_W-1:0] prog_data_i,
  // Decoder results for the word in execute
  output logic [program_sequencer_pkg::WORD_W-1:0] instr_o,
  output logic                            instr_valid_o,
  input  wire logic [2:0]                 op_class_i,
  input  wire logic [program_sequencer_pkg::PC_W-1:0]   op_target_i,
  input  wire logic                       skip_met_i,
  // Table read results
  output logic [program_sequencer_pkg::DATA_W-1:0] tab_low_o,
  output logic                            tab_low_valid_o,
  // Interrupt requests (pulses or levels from peripherals)
  input  wire logic                       ext_irq_a_i,
  input  wire logic                       ext_irq_b_i,
  input  wire logic                       tmr_a_ovf_i,
  input  wire logic                       tmr_b_ovf_i,
  input  wire logic                       serial_done_i,
  input  wire logic                       multi_irq_i,
  output logic [5:0]                      irq_ack_o,
  // Register port
  input  wire logic [program_sequencer_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [program_sequencer_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic [program_sequencer_pkg::DATA_W-1:0] reg_rdata_o,
  // Phase and state
  output logic [1:0]                      phase_o,
  output logic                            running_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int SP_W = $clog2(DEPTH);

  logic [1:0]        phase_r;        // Phase within instruction cycle
  logic              cyc_end;        // Last phase of a cycle
  logic [11:0]       startup_cnt_r;  // Start-up hold counter
  logic              running_r;      // Instructions may run
  logic [PC_W-1:0]   pc_r;           // Instruction pointer
  logic [PC_W-1:0]   pc_nxt;         // Next instruction pointer
  logic [WORD_W-1:0] instr_r;        // Word in execute stage
  logic              valid_r;        // Execute stage holds a real word
  logic              valid_nxt;      // Fetched word will be kept
  logic              tab_pend_r;     // Table read second cycle
  logic [PC_W-1:0]   tab_addr_r;     // Table word address
  logic [PC_W-1:0]   tab_addr_nxt;   // Table word address to load
  logic              tab_start;      // Table read begins
  logic [7:0]        table_pointer_r;         // Table pointer register
  logic [7:0]        table_high_byte_r;         // Table high byte register
  logic [DATA_W-1:0] tab_low_r;      // Table low byte output
  logic              tab_low_v_r;    // Table low byte strobe
  logic [PC_W-1:0]   stack_r [DEPTH]; // Return stack
  logic [SP_W:0]     sp_r;           // Stack occupancy
  logic              stack_full;     // All levels used
  logic              push;           // Store return address
  logic              pop;            // Restore return address
  logic [PC_W-1:0]   push_val;       // Address to store
  logic [5:0]        irq_flag_r;     // Sticky request flags
  logic [5:0]        irq_sync1_r;    // First sync stage
  logic [5:0]        irq_sync2_r;    // Second sync stage
  logic [5:0]        irq_prev_r;     // Previous synced level
  logic [5:0]        irq_en_r;       // Per-source enable
  logic              glob_en_r;      // Global enable
  logic [5:0]        irq_ready;      // Enabled pending requests
  logic [5:0]        irq_take;       // One-hot granted request
  logic              irq_go;         // Acknowledge this cycle
  logic [PC_W-1:0]   irq_vec;        // Granted vector
  logic              pcl_wr;         // Low byte write
  logic              pcl_seen_r;     // Low byte written inside this cycle
  logic [DATA_W-1:0] rdata_r;        // Read data register
  logic [5:0]        ack_r;          // Acknowledge pulse
  op_class_e         op;             // Decoded class

  assign op = op_class_e'(op_class_i);

  // Priority picker: lowest index wins
  function automatic logic [5:0] pick_lowest(input logic [5:0] req);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 5; i >= 0; i--) begin
      if (req[i]) begin
        res = 6'h00;
        res[i] = 1'b1;
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timing

  // Four-phase divider
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= 2'h0;
    end else if (!running_r) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign cyc_end = running_r && (phase_r == PHASES_PER_CYCLE);

  // Start-up hold after reset or wake
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      startup_cnt_r <= 12'h000;
      running_r     <= 1'b0;
    end else if (wake_i) begin
      startup_cnt_r <= 12'h000;
      running_r     <= 1'b0;
    end else if (!running_r) begin
      if (startup_cnt_r == 12'(STARTUP_LEN - 1)) begin
        running_r <= 1'b1;
      end else begin
        startup_cnt_r <= startup_cnt_r + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Sync and edge detect request inputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_sync1_r <= 6'h00;
      irq_sync2_r <= 6'h00;
      irq_prev_r  <= 6'h00;
    end else begin
      irq_sync1_r <= {multi_irq_i, serial_done_i, tmr_b_ovf_i, tmr_a_ovf_i,
                      ext_irq_b_i, ext_irq_a_i};
      irq_sync2_r <= irq_sync1_r;
      irq_prev_r  <= irq_sync2_r;
    end
  end

  assign irq_ready = irq_flag_r & irq_en_r & {6{glob_en_r}};
  assign irq_take  = pick_lowest(irq_ready);
  assign irq_go    = cyc_end && (irq_ready != 6'h00) && !stack_full
                     && !tab_pend_r && valid_r && (op == OP_PLAIN) && !skip_met_i;

  // Vector select
  always_comb begin
    irq_vec = VEC_MULTI;
    if (irq_take[0]) irq_vec = VEC_EXT_A;
    else if (irq_take[1]) irq_vec = VEC_EXT_B;
    else if (irq_take[2]) irq_vec = VEC_TMR_A;
    else if (irq_take[3]) irq_vec = VEC_TMR_B;
    else if (irq_take[4]) irq_vec = VEC_SERIAL;
  end

  // Sticky flags, set beats clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_flag_r <= 6'h00;
      ack_r      <= 6'h00;
    end else begin
      irq_flag_r <= (irq_flag_r & ~(irq_go ? irq_take : 6'h00))
                    | (irq_sync2_r & ~irq_prev_r);
      ack_r      <= irq_go ? irq_take : 6'h00;
    end
  end

  // Enables: global off on acknowledge, on at return from interrupt
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_r  <= 6'h00;
      glob_en_r <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == OFF_IRQ_ENABLE) begin
        irq_en_r  <= reg_wdata_i[5:0];
        glob_en_r <= reg_wdata_i[7];
      end else if (irq_go) begin
        glob_en_r <= 1'b0;
      end else if (cyc_end && valid_r && op == OP_RETURN_IRQ) begin
        glob_en_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  assign pcl_wr    = reg_wr_i && (reg_addr_i == OFF_COUNTER_LOW);
  assign tab_start = cyc_end && valid_r && !tab_pend_r
                     && (op == OP_TAB_CUR || op == OP_TAB_LAST);
  assign push      = irq_go || (cyc_end && valid_r && !tab_pend_r && op == OP_CALL);
  assign pop       = cyc_end && valid_r && !tab_pend_r && (op == OP_RET || op == OP_RETURN_IRQ);
  assign push_val  = pc_r;
  assign stack_full = (sp_r == (SP_W+1)'(DEPTH));

  // Table address
  always_comb begin
    if (op == OP_TAB_LAST) begin
      tab_addr_nxt = {LAST_PAGE_HI, table_pointer_r};
    end else begin
      tab_addr_nxt = {pc_r[12:8], table_pointer_r};
    end
  end

  // Next counter and whether the fetched word is kept
  always_comb begin
    pc_nxt    = pc_r + 13'h0001;
    valid_nxt = 1'b1;
    if (irq_go) begin
      pc_nxt    = irq_vec;
      valid_nxt = 1'b0;
    end else if (!valid_r || tab_pend_r) begin
      pc_nxt    = pc_r + 13'h0001;
    end else if (skip_met_i) begin
      pc_nxt    = pc_r + 13'h0001;
      valid_nxt = 1'b0;
    end else begin
      case (op)
        OP_JUMP, OP_CALL: begin
          pc_nxt    = op_target_i;
          valid_nxt = 1'b0;
        end
        OP_RET, OP_RETURN_IRQ: begin
          pc_nxt    = stack_r[sp_r[SP_W-1:0] - SP_W'(1)];
          valid_nxt = 1'b0;
        end
        OP_TAB_CUR, OP_TAB_LAST: begin
          pc_nxt    = pc_r;
          valid_nxt = 1'b0;
        end
        default: begin
          pc_nxt    = pc_r + 13'h0001;
        end
      endcase
    end
  end

  // Counter register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_r <= PC_RESET;
      pcl_seen_r <= 1'b0;
    end else if (pcl_wr) begin
      pc_r <= {pc_r[12:8], reg_wdata_i};
      pcl_seen_r <= !cyc_end;
    end else if (cyc_end) begin
      pc_r <= pcl_seen_r ? pc_r : pc_nxt;
      pcl_seen_r <= 1'b0;
    end
  end

  // Execute stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instr_r <= 16'h0000;
      valid_r <= 1'b0;
    end else if (pcl_wr) begin
      valid_r <= 1'b0;
    end else if (cyc_end && tab_pend_r) begin
      valid_r <= 1'b1;
    end else if (cyc_end) begin
      instr_r <= prog_data_i;
      valid_r <= valid_nxt && !pcl_seen_r;
    end
  end

  // Table read second cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tab_pend_r  <= 1'b0;
      tab_addr_r  <= PC_RESET;
      table_high_byte_r      <= TABLE_HIGH_BYTE_RESET;
      tab_low_r   <= 8'h00;
      tab_low_v_r <= 1'b0;
    end else begin
      tab_low_v_r <= 1'b0;
      if (tab_start) begin
        tab_pend_r <= 1'b1;
        tab_addr_r <= tab_addr_nxt;
      end else if (cyc_end && tab_pend_r) begin
        tab_pend_r  <= 1'b0;
        tab_low_r   <= prog_data_i[7:0];
        table_high_byte_r      <= prog_data_i[15:8];
        tab_low_v_r <= 1'b1;
      end
    end
  end

  // Table pointer register written by software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      table_pointer_r <= TABLE_POINTER_RESET;
    end else if (reg_wr_i && reg_addr_i == OFF_TABLE_PTR) begin
      table_pointer_r <= reg_wdata_i;
    end
  end

  // Return stack; full stack call drops the oldest
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        stack_r[i] <= PC_RESET;
      end
    end else if (push) begin
      if (stack_full) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          stack_r[i] <= stack_r[i+1];
        end
        stack_r[DEPTH-1] <= push_val;
      end else begin
        stack_r[sp_r[SP_W-1:0]] <= push_val;
        sp_r <= sp_r + (SP_W+1)'(1);
      end
    end else if (pop && sp_r != '0) begin
      sp_r <= sp_r - (SP_W+1)'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Read data one cycle later
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_COUNTER_LOW: rdata_r <= pc_r[7:0];
        OFF_TABLE_PTR:   rdata_r <= table_pointer_r;
        OFF_TABLE_HIGH:  rdata_r <= table_high_byte_r;
        OFF_SEQ_STATUS:  rdata_r <= {running_r, stack_full, 1'b0, sp_r[SP_W:0]};
        OFF_IRQ_ENABLE:  rdata_r <= {glob_en_r, 1'b0, irq_en_r};
        default:         rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Registered fetch address
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_addr_o <= PC_RESET;
      prog_rd_o   <= 1'b0;
    end else begin
      prog_addr_o <= tab_pend_r ? tab_addr_r : pc_r;
      prog_rd_o   <= running_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instr_o         <= 16'h0000;
      instr_valid_o   <= 1'b0;
      tab_low_o       <= 8'h00;
      tab_low_valid_o <= 1'b0;
      irq_ack_o       <= 6'h00;
      phase_o         <= 2'h0;
      running_o       <= 1'b0;
    end else begin
      instr_o         <= instr_r;
      instr_valid_o   <= valid_r && !tab_pend_r;
      tab_low_o       <= tab_low_r;
      tab_low_valid_o <= tab_low_v_r;
      irq_ack_o       <= ack_r;
      phase_o         <= phase_r;
      running_o       <= running_r;
    end
  end

endmodule

// file: design/program_sequencer_pkg.sv
// Constants shared by the program sequencer
package program_sequencer_pkg;

  // Widths
  localparam int PC_W    = 13;
  localparam int WORD_W  = 16;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 8;

  // Instruction cycle phases
  localparam logic [1:0] PHASES_PER_CYCLE = 2'h3;

  // Register offsets
  localparam logic [7:0] OFF_COUNTER_LOW  = 8'h06;
  localparam logic [7:0] OFF_TABLE_PTR    = 8'h07;
  localparam logic [7:0] OFF_TABLE_HIGH   = 8'h08;
  localparam logic [7:0] OFF_SEQ_STATUS   = 8'h30;
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h31;

  // Reset values
  localparam logic [12:0] PC_RESET       = 13'h0000;
  localparam logic [7:0]  TABLE_POINTER_RESET     = 8'h00;
  localparam logic [7:0]  TABLE_HIGH_BYTE_RESET     = 8'h00;
  localparam logic [6:0]  IRQ_EN_RESET   = 7'h00;

  // Vectors
  localparam logic [12:0] VEC_EXT_A   = 13'h0004;
  localparam logic [12:0] VEC_EXT_B   = 13'h0008;
  localparam logic [12:0] VEC_TMR_A   = 13'h000C;
  localparam logic [12:0] VEC_TMR_B   = 13'h0010;
  localparam logic [12:0] VEC_SERIAL  = 13'h0014;
  localparam logic [12:0] VEC_MULTI   = 13'h0018;

  // Last page high bits
  localparam logic [4:0] LAST_PAGE_HI = 5'h1F;

  // Start-up delay in system clock periods
  localparam int STARTUP_PERIODS = 1024;
  localparam int SYS_CLK_NS      = 20;
  localparam int STARTUP_CYCLES  = (STARTUP_PERIODS * SYS_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // Stack depth
  localparam int STACK_DEPTH = 16;

  // Instruction classes issued by the decoder
  typedef enum logic [2:0] {
    OP_PLAIN, OP_JUMP, OP_CALL, OP_RET, OP_RETURN_IRQ, OP_TAB_CUR, OP_TAB_LAST
  } op_class_e;

endpackage

// file: dv/program_memory_model.sv
// Behavioural program memory answering the sequencer's fetches
`timescale 1ns/10ps
module program_memory_model
  import program_sequencer_pkg::*;
(
  // Clock
  input  wire logic                                    clk_i,
  // Fetch side
  input  wire logic [program_sequencer_pkg::PC_W-1:0]  addr_i,
  input  wire logic                                    rd_i,
  input  wire logic                                    slow_i,
  output logic [program_sequencer_pkg::WORD_W-1:0]    data_o
);
  // Extra stage for slow answers
  logic [WORD_W-1:0] stage_r;

  // Word encodes its own address; the page shows in both bytes
  function automatic logic [WORD_W-1:0] word_at(input logic [PC_W-1:0] a);
    return {3'h5, a[12:8], a[7:0] ^ {3'h0, a[12:8]}};
  endfunction

  initial data_o = 16'hA5A5;

  // One clock latency, two when slow; idle data toggles every clock
  always @(posedge clk_i) begin
    stage_r <= word_at(addr_i);
    if (!rd_i) begin
      data_o <= ~data_o;
    end else if (slow_i) begin
      data_o <= stage_r;
    end else begin
      data_o <= word_at(addr_i);
    end
  end
endmodule

// file: dv/program_sequencer_monitor.sv
// Concurrent checks on the program sequencer ports
`timescale 1ns/10ps
module program_sequencer_monitor
  import program_sequencer_pkg::*;
#(
  parameter int STARTUP_LEN = 16
) (
  // Clock and reset
  input wire logic                                     clk_i,
  input wire logic                                     rst_n_i,
  // Watched ports
  input wire logic                                     wake_i,
  input wire logic [program_sequencer_pkg::PC_W-1:0]   prog_addr_o,
  input wire logic                                     prog_rd_o,
  input wire logic                                     tab_low_valid_o,
  input wire logic [5:0]                               irq_ack_o,
  input wire logic                                     reg_rd_i,
  input wire logic [program_sequencer_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [1:0]                               phase_o,
  input wire logic                                     running_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  localparam int HOLD_MAX = STARTUP_LEN + 4;
  int              hold_cnt; // Clocks since reset or wake
  logic [PC_W-1:0] vec_r;    // Vector of the last acknowledge

  ////////////////////////////////////////////////////////////////
  // Start-up counter, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt <= 0;
    end else if (wake_i) begin
      hold_cnt <= 0;
    end else if (hold_cnt < HOLD_MAX) begin
      hold_cnt <= hold_cnt + 1;
    end
  end

  // Vector expected for the acknowledged source
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_r <= 13'h0000;
    end else begin
      case (irq_ack_o)
        6'h01: vec_r <= VEC_EXT_A;
        6'h02: vec_r <= VEC_EXT_B;
        6'h04: vec_r <= VEC_TMR_A;
        6'h08: vec_r <= VEC_TMR_B;
        6'h10: vec_r <= VEC_SERIAL;
        6'h20: vec_r <= VEC_MULTI;
        default: vec_r <= vec_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  a_phase_steps: assert property (running_o && $past(running_o)
    |-> phase_o == $past(phase_o) + 2'h1) else $error("phase did not step");
  a_hold_quiet: assert property (hold_cnt >= 3 && hold_cnt < STARTUP_LEN - 2
    |-> !running_o) else $error("running during start-up hold");
  a_hold_ends: assert property (hold_cnt == HOLD_MAX |-> running_o)
    else $error("start-up hold too long");
  a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data without read strobe");
  a_ack_onehot: assert property ($onehot0(irq_ack_o))
    else $error("several sources acknowledged");
  a_ack_single: assert property (irq_ack_o != 6'h00 |=> irq_ack_o == 6'h00 [*3])
    else $error("acknowledge not a single pulse");
  a_ack_vector: assert property (irq_ack_o != 6'h00
    |=> ##[0:12] prog_addr_o == vec_r) else $error("vector not fetched");
  a_tab_pulse: assert property (tab_low_valid_o |=> !tab_low_valid_o)
    else $error("table byte strobe too long");
  a_fetch_on: assert property (running_o && $past(running_o) |-> prog_rd_o)
    else $error("no fetch while running");

  c_ack: cover property (irq_ack_o != 6'h00);
  c_table: cover property (tab_low_valid_o);
  c_start: cover property ($rose(running_o));
endmodule

bind program_sequencer program_sequencer_monitor #(.STARTUP_LEN(STARTUP_LEN)) i_mon (
  .clk_i, .rst_n_i, .wake_i, .prog_addr_o, .prog_rd_o, .tab_low_valid_o,
  .irq_ack_o, .reg_rd_i, .reg_rdata_o, .phase_o, .running_o);

// file: dv/test_program_sequencer.sv
// Self-checking bench for the program sequencer
`timescale 1ns/10ps
module test_program_sequencer;
  import program_sequencer_pkg::*;
  localparam int HOLD = 16;
  // Program row: word, class, target, skip, next word, clocks to next
  typedef struct {
    logic [12:0] src;
    op_class_e   op;
    logic [12:0] tgt;
    logic        skp;
    logic [12:0] nxt;
    int          gap;
  } row_s;
  // Stimulus
  logic              clk_i = 1'b0, rst_n_i = 1'b0, wake_i = 1'b0, slow = 1'b0;
  logic [2:0]        op_class_i = 3'h0;
  logic [PC_W-1:0]   op_target_i = 13'h0000;
  logic              skip_met_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [5:0]        irq_v = 6'h00;
  logic [7:0]        reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  // Design outputs
  logic [WORD_W-1:0] prog_data_i, instr_o, prev_w;
  logic [PC_W-1:0]   prog_addr_o, last_a, ea;
  logic [7:0]        tab_low_o, reg_rdata_o, d;
  logic [5:0]        irq_ack_o;
  logic [1:0]        phase_o;
  logic              prog_rd_o, instr_valid_o, tab_low_valid_o, running_o, prev_v;
  // Bench state
  int                err_count = 0, checked = 0, cyc = 0, j;
  logic [12:0]       trace_a[$];
  int                trace_t[$];
  logic [7:0]        tab_q[$];
  logic [5:0]        ack_q[$];
  row_s              rows[10];

  always #10 clk_i = ~clk_i;

  program_sequencer #(.STARTUP_LEN(HOLD)) i_dut (
    .clk_i, .rst_n_i, .wake_i, .prog_addr_o, .prog_rd_o, .prog_data_i,
    .instr_o, .instr_valid_o, .op_class_i, .op_target_i, .skip_met_i,
    .tab_low_o, .tab_low_valid_o, .ext_irq_a_i(irq_v[0]), .ext_irq_b_i(irq_v[1]),
    .tmr_a_ovf_i(irq_v[2]), .tmr_b_ovf_i(irq_v[3]), .serial_done_i(irq_v[4]),
    .multi_irq_i(irq_v[5]), .irq_ack_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .phase_o, .running_o);
  program_memory_model i_mem (.clk_i, .addr_i(prog_addr_o), .rd_i(prog_rd_o),
    .slow_i(slow), .data_o(prog_data_i));

  ////////////////////////////////////////////////////////////////
  // Address a fetched word came from
  function automatic logic [12:0] addr_of(input logic [15:0] w);
    return {w[12:8], w[7:0] ^ {3'h0, w[12:8]}};
  endfunction

  // Decoder stand-in: class from the row table, handlers end in return
  always @(posedge clk_i) begin
    ea = addr_of(instr_o);
    op_class_i <= OP_PLAIN;
    op_target_i <= 13'h0000;
    skip_met_i <= 1'b0;
    if (instr_valid_o === 1'b1) begin
      foreach (rows[i]) if (rows[i].src == ea) begin
        op_class_i <= rows[i].op;
        op_target_i <= rows[i].tgt;
        skip_met_i <= rows[i].skp;
      end
      if (ea inside {[13'h0006:13'h001A]} && ea[1:0] == 2'h2) op_class_i <= OP_RETURN_IRQ;
    end
  end

  // Trace of executed words, table bytes and acknowledges
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (instr_valid_o === 1'b1 && (instr_o !== prev_w || prev_v !== 1'b1)) begin
      trace_a.push_back(addr_of(instr_o));
      trace_t.push_back(cyc);
      last_a <= addr_of(instr_o);
    end
    prev_w <= instr_o;
    prev_v <= instr_valid_o;
    if (tab_low_valid_o === 1'b1) tab_q.push_back(tab_low_o);
    if (irq_ack_o !== 6'h00) ack_q.push_back(irq_ack_o);
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
    @(posedge clk_i);
  endtask

  task automatic pulse(input logic [5:0] m);
    irq_v <= m;
    repeat (4) @(posedge clk_i);
    irq_v <= 6'h00;
  endtask

  task automatic wait_exec(input logic [12:0] a, input int lim);
    for (int n = 0; n < lim && last_a !== a; n++) @(posedge clk_i);
    chk(16'(last_a), 16'(a));
  endtask

  task automatic wait_ack(input int cnt);
    for (int n = 0; n < 300 && ack_q.size() < cnt; n++) @(posedge clk_i);
    chk(16'(ack_q.size()), 16'(cnt));
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{13'h000, OP_PLAIN, 13'h000, 1'b0, 13'h001, 4},
      '{13'h003, OP_JUMP, 13'h040, 1'b0, 13'h040, 8},
      '{13'h040, OP_PLAIN, 13'h000, 1'b0, 13'h041, 4},
      '{13'h041, OP_PLAIN, 13'h000, 1'b1, 13'h043, 8},
      '{13'h043, OP_CALL, 13'h100, 1'b0, 13'h100, 8},
      '{13'h101, OP_RET, 13'h000, 1'b0, 13'h044, 8},
      '{13'h044, OP_TAB_CUR, 13'h000, 1'b0, 13'h045, 8},
      '{13'h045, OP_TAB_LAST, 13'h000, 1'b0, 13'h046, 8},
      '{13'h046, OP_JUMP, 13'h150, 1'b0, 13'h150, 8},
      '{13'h160, OP_JUMP, 13'h150, 1'b0, 13'h150, 8}};
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reg_rd(OFF_TABLE_PTR, d);
    chk(16'(d), 16'(TABLE_POINTER_RESET));
    reg_rd(OFF_TABLE_HIGH, d);
    chk(16'(d), 16'(TABLE_HIGH_BYTE_RESET));
    reg_wr(OFF_TABLE_HIGH, 8'hFF);
    reg_rd(OFF_TABLE_HIGH, d);
    chk(16'(d), 16'(TABLE_HIGH_BYTE_RESET));
    reg_wr(OFF_TABLE_PTR, 8'h7E);
    reg_rd(OFF_TABLE_PTR, d);
    chk(16'(d), 16'h007E);
    reg_rd(8'h3F, d);
    chk(16'(d), 16'h0000);
    chk(16'(running_o), 16'h0000);
    $display("register test done");
    // Program flow rows
    wait_exec(13'h160, 600);
    repeat (16) @(posedge clk_i);
    chk(16'(trace_a[0]), 16'(PC_RESET));
    foreach (rows[i]) begin
      j = -1;
      foreach (trace_a[k]) if (j < 0 && trace_a[k] == rows[i].src) j = k;
      if (j < 0) j = trace_a.size() - 2;
      chk(16'(trace_a[j+1]), 16'(rows[i].nxt));
      chk(16'(trace_t[j+1] - trace_t[j]), 16'(rows[i].gap));
    end
    chk(16'(tab_q.size()), 16'h0002);
    chk(16'(tab_q[0]), 16'h007E);
    chk(16'(tab_q[1]), 16'h0061);
    reg_rd(OFF_TABLE_HIGH, d);
    chk(16'(d), 16'h00BF);
    $display("flow test done");
    // Short jump keeps the upper counter bits
    reg_wr(OFF_COUNTER_LOW, 8'h30);
    wait_exec(13'h130, 40);
    $display("short jump test done");
    // Each source: masked first, then enabled; slow memory meanwhile
    slow <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      reg_wr(OFF_IRQ_ENABLE, 8'h80);
      ack_q.delete();
      pulse(6'h01 << k);
      repeat (40) @(posedge clk_i);
      chk(16'(ack_q.size()), 16'h0000);
      reg_wr(OFF_IRQ_ENABLE, 8'h80 | (8'h01 << k));
      wait_ack(1);
      chk(16'(ack_q[0]), 16'(6'h01 << k));
      repeat (40) @(posedge clk_i);
    end
    // Two sources at once: lower vector first
    ack_q.delete();
    reg_wr(OFF_IRQ_ENABLE, 8'h86);
    pulse(6'h06);
    wait_ack(2);
    chk(16'(ack_q[0]), 16'h0002);
    chk(16'(ack_q[1]), 16'h0004);
    $display("interrupt test done");
    // Wake restarts the start-up hold
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(16'(running_o), 16'h0000);
    repeat (HOLD + 8) @(posedge clk_i);
    chk(16'(running_o), 16'h0001);
    // Second reset in mid-run restarts at word zero
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(16'(prog_addr_o), 16'(PC_RESET));
    trace_a.delete();
    trace_t.delete();
    rst_n_i <= 1'b1;
    wait_exec(13'h001, HOLD + 60);
    chk(16'(trace_a[0]), 16'(PC_RESET));
    $display("wake and reset test done");
    close_out();
  end
endmodule
